/* hw/terminal_status_word_exchange.sv */
// terminal side of the control/notify word exchange with the host controller
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
module terminal_status_word_exchange
  import status_xchg_pkg::*;
#(
  parameter int GM_CTL_WORDS = status_xchg_pkg::CTL_GM_WORDS,
  parameter int GM_NTF_WORDS = status_xchg_pkg::NTF_GM_WORDS
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  // configuration pin
  input wire logic general_memory_switch_i,
  // register port (host memory image)
  input wire logic [status_xchg_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [status_xchg_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [status_xchg_pkg::DATA_W-1:0] reg_rdata_o,
  // terminal events from the display engine
  input wire logic screen_change_i,
  input wire logic [status_xchg_pkg::DATA_W-1:0] screen_num_i,
  input wire logic numeral_entry_i,
  input wire logic [11:0] numeral_table_i,
  input wire logic [status_xchg_pkg::DATA_W-1:0] numeral_value_i,
  input wire logic touch_change_i,
  input wire logic [status_xchg_pkg::DATA_W-1:0] touch_bits_i,
  input wire logic [2:0] touch_word_i,
  input wire logic string_change_i,
  input wire logic running_i,
  input wire logic battery_low_i,
  // write-back channel towards the link (value, kind)
  output logic wb_valid_o,
  output logic [1:0] wb_kind_o,
  output logic [status_xchg_pkg::DATA_W-1:0] wb_data_o,
  // element poll channel: request, answer from host
  output logic poll_req_o,
  input wire logic poll_ack_i,
  input wire logic [status_xchg_pkg::DATA_W-1:0] poll_data_i,
  output logic [status_xchg_pkg::DATA_W-1:0] element_word_o,
  // decoded terminal controls
  output logic [status_xchg_pkg::DATA_W-1:0] screen_select_o,
  output logic [11:0] copy_source_o,
  output logic [11:0] copy_target_o,
  output logic [3:0] copy_type_o,
  output logic backlight_on_o,
  output logic alarm_o,
  output logic buzzer_cont_o,
  output logic buzzer_inter_o,
  output logic history_clear_o,
  output logic backlight_red_o,
  output logic backlight_steady_o,
  output logic [status_xchg_pkg::DATA_W-1:0] ctl_gm_bits_o [status_xchg_pkg::CTL_GM_WORDS],
  output logic gm_enabled_o
);
  import status_xchg_pkg::*;

  // ******************************************************************
  // state
  // ******************************************************************
  typedef struct packed {
    logic [1:0] sw_sync;
    logic [1:0] run_sync;
    logic [1:0] batt_sync;
    logic gm_en;
    logic [AREA_WORDS_GM-1:0][DATA_W-1:0] ctl;
    logic [AREA_WORDS_GM-1:0][DATA_W-1:0] ntf;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] elem;
    logic poll_busy;
    logic scr_pend;
    logic num_pend;
    logic touch_pend;
    logic str_pend;
    logic scr_stb_clr;
    logic num_stb_clr;
    logic last_run;
    logic last_batt;
    logic state_pend;
    logic [DATA_W-1:0] num_val;
    logic wb_valid;
    logic [1:0] wb_kind;
    logic [DATA_W-1:0] wb_data;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  // kept apart from the state struct: it runs on the raw reset, not on its own output
  logic [1:0] rst_sync_ff;
  logic rst_n;

  assign rst_n = rst_sync_ff[1];

  // ******************************************************************
  // address decoding
  // ******************************************************************
  // area length for the current switch setting
  function automatic logic in_area(input logic [ADDR_W-1:0] ofs, input logic gm, input int nogm_words);
    in_area = gm ? (int'(ofs) < AREA_WORDS_GM) : (int'(ofs) < nogm_words);
  endfunction

  // word of the control image that exists at this switch setting
  function automatic logic ctl_hit(input logic [ADDR_W-1:0] addr, input logic gm);
    logic [ADDR_W-1:0] ofs;
    ofs = addr & WORD_OFS_MASK;
    ctl_hit = (addr < NTF_BASE_IDX) && in_area(ofs, gm, CTL_WORDS_NOGM);
  endfunction

  // notify image word; the config index above it is decoded first
  function automatic logic ntf_hit(input logic [ADDR_W-1:0] addr, input logic gm);
    logic [ADDR_W-1:0] ofs;
    ofs = addr & WORD_OFS_MASK;
    ntf_hit = (addr >= NTF_BASE_IDX) && (addr != CFG_IDX) && in_area(ofs, gm, NTF_WORDS_NOGM);
  endfunction

  // two-flop synchroniser step: new sample in, older sample moves up
  function automatic logic [1:0] sync_step(input logic [1:0] q, input logic d);
    sync_step = {q[0], d};
  endfunction

  // ******************************************************************
  // reset release
  // ******************************************************************
  // release waits two edges so no flop leaves reset on a half-settled edge
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  // ******************************************************************
  // next state
  // ******************************************************************
  always_comb begin
    logic [ADDR_W-1:0] ofs;
    logic [DATA_W-1:0] stw;
    nxt_st = st_ff;
    ofs = reg_addr_i & WORD_OFS_MASK;
    stw = ZERO_W;
    // pin inputs through two flops
    nxt_st.sw_sync = sync_step(st_ff.sw_sync, general_memory_switch_i);
    nxt_st.run_sync = sync_step(st_ff.run_sync, running_i);
    nxt_st.batt_sync = sync_step(st_ff.batt_sync, battery_low_i);
    nxt_st.gm_en = st_ff.sw_sync[1];
    nxt_st.wb_valid = 1'b0;

    // ****************************************************************
    // register port
    // ****************************************************************
    // host writes into the control image; out-of-area words ignored
    if (reg_wr_i) begin
      if (ctl_hit(reg_addr_i, st_ff.gm_en)) begin
        nxt_st.ctl[ofs[3:0]] = reg_wdata_i;
      end
    end

    // register reads: data stands the next cycle only
    nxt_st.rdata = ZERO_W;
    if (reg_rd_i) begin
      if (reg_addr_i == CFG_IDX) begin
        nxt_st.rdata = DATA_W'(st_ff.gm_en);
      end else if (ctl_hit(reg_addr_i, st_ff.gm_en)) begin
        nxt_st.rdata = st_ff.ctl[ofs[3:0]];
      end else if (ntf_hit(reg_addr_i, st_ff.gm_en)) begin
        nxt_st.rdata = st_ff.ntf[ofs[3:0]];
      end
    end

    // ****************************************************************
    // element poll
    // ****************************************************************
    // element poll: request, take answer, refresh display word
    if (!st_ff.poll_busy) begin
      nxt_st.poll_busy = 1'b1;
    end else if (poll_ack_i) begin
      nxt_st.elem = poll_data_i;
      nxt_st.poll_busy = 1'b0;
    end

    // ****************************************************************
    // terminal events
    // ****************************************************************
    // events latch pending writes; set wins over clear, except for the run/battery state flag, where the clear wins
    if (screen_change_i) begin
      nxt_st.ntf[CURRENT_SCREEN_OFS[3:0]] = screen_num_i;
      nxt_st.scr_pend = 1'b1;
    end
    if (numeral_entry_i) begin
      nxt_st.ntf[CHANGED_TABLE_OFS[3:0]] = {4'h0, numeral_table_i};
      nxt_st.num_val = numeral_value_i;
      nxt_st.num_pend = 1'b1;
    end
    if (touch_change_i) begin
      if (st_ff.gm_en && int'(touch_word_i) < GM_NTF_WORDS) begin
        nxt_st.ntf[NTF_WORDS_NOGM + int'(touch_word_i)] = touch_bits_i;
      end
      nxt_st.touch_pend = 1'b1;
    end
    if (string_change_i) begin
      nxt_st.str_pend = 1'b1;
    end
    nxt_st.last_run = st_ff.run_sync[1];
    nxt_st.last_batt = st_ff.batt_sync[1];
    if (st_ff.run_sync[1] != st_ff.last_run || st_ff.batt_sync[1] != st_ff.last_batt) begin
      nxt_st.state_pend = 1'b1;
    end

    // terminal state word: only defined bits can be one
    stw[NB_RUN] = st_ff.run_sync[1];
    stw[NB_BATT_LOW] = st_ff.batt_sync[1];
    stw[NB_SCR_STB] = st_ff.ntf[TERMINAL_STATE_OFS[3:0]][NB_SCR_STB];
    stw[NB_NUM_STB] = st_ff.ntf[TERMINAL_STATE_OFS[3:0]][NB_NUM_STB];

    // strobes clear one cycle after their write-back transfer (notify or numeral) went out
    if (st_ff.scr_stb_clr) begin
      stw[NB_SCR_STB] = 1'b0;
      nxt_st.scr_stb_clr = 1'b0;
    end
    if (st_ff.num_stb_clr) begin
      stw[NB_NUM_STB] = 1'b0;
      nxt_st.num_stb_clr = 1'b0;
    end

    // ****************************************************************
    // write-back
    // ****************************************************************
    // one write per cycle, priority notify, touch, numeral, string
    if (st_ff.scr_pend || st_ff.state_pend) begin
      if (st_ff.scr_pend) begin
        stw[NB_SCR_STB] = 1'b1;
        nxt_st.scr_stb_clr = 1'b1;
        nxt_st.scr_pend = screen_change_i;
      end
      nxt_st.state_pend = 1'b0;
      nxt_st.wb_valid = 1'b1;
      nxt_st.wb_kind = WK_NOTIFY;
      nxt_st.wb_data = stw;
    end else if (st_ff.touch_pend) begin
      nxt_st.touch_pend = touch_change_i;
      nxt_st.wb_valid = 1'b1;
      nxt_st.wb_kind = WK_TOUCH;
      // live bits, so a key still held is reported as pressed
      nxt_st.wb_data = touch_bits_i;
    end else if (st_ff.num_pend) begin
      stw[NB_NUM_STB] = 1'b1;
      nxt_st.num_stb_clr = 1'b1;
      nxt_st.num_pend = numeral_entry_i;
      nxt_st.wb_valid = 1'b1;
      nxt_st.wb_kind = WK_NUMERAL;
      nxt_st.wb_data = st_ff.num_val;
    end else if (st_ff.str_pend) begin
      nxt_st.str_pend = string_change_i;
      nxt_st.wb_valid = 1'b1;
      nxt_st.wb_kind = WK_STRING;
      nxt_st.wb_data = ZERO_W;
    end
    nxt_st.ntf[TERMINAL_STATE_OFS[3:0]] = stw;
  end

  // ******************************************************************
  // state register
  // ******************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.sw_sync <= 2'h0;
      st_ff.run_sync <= 2'h0;
      st_ff.batt_sync <= 2'h0;
      st_ff.gm_en <= 1'b0;
      st_ff.ctl <= '0;
      st_ff.ntf <= '0;
      st_ff.rdata <= ZERO_W;
      st_ff.elem <= ZERO_W;
      st_ff.poll_busy <= 1'b0;
      st_ff.scr_pend <= 1'b0;
      st_ff.num_pend <= 1'b0;
      st_ff.touch_pend <= 1'b0;
      st_ff.str_pend <= 1'b0;
      st_ff.scr_stb_clr <= 1'b0;
      st_ff.num_stb_clr <= 1'b0;
      st_ff.last_run <= 1'b0;
      st_ff.last_batt <= 1'b0;
      st_ff.state_pend <= 1'b0;
      st_ff.num_val <= ZERO_W;
      st_ff.wb_valid <= 1'b0;
      st_ff.wb_kind <= 2'h0;
      st_ff.wb_data <= ZERO_W;
    end else if (clk_en_i) begin
      st_ff.sw_sync <= nxt_st.sw_sync;
      st_ff.run_sync <= nxt_st.run_sync;
      st_ff.batt_sync <= nxt_st.batt_sync;
      st_ff.gm_en <= nxt_st.gm_en;
      st_ff.ctl <= nxt_st.ctl;
      st_ff.ntf <= nxt_st.ntf;
      st_ff.rdata <= nxt_st.rdata;
      st_ff.elem <= nxt_st.elem;
      st_ff.poll_busy <= nxt_st.poll_busy;
      st_ff.scr_pend <= nxt_st.scr_pend;
      st_ff.num_pend <= nxt_st.num_pend;
      st_ff.touch_pend <= nxt_st.touch_pend;
      st_ff.str_pend <= nxt_st.str_pend;
      st_ff.scr_stb_clr <= nxt_st.scr_stb_clr;
      st_ff.num_stb_clr <= nxt_st.num_stb_clr;
      st_ff.last_run <= nxt_st.last_run;
      st_ff.last_batt <= nxt_st.last_batt;
      st_ff.state_pend <= nxt_st.state_pend;
      st_ff.num_val <= nxt_st.num_val;
      st_ff.wb_valid <= nxt_st.wb_valid;
      st_ff.wb_kind <= nxt_st.wb_kind;
      st_ff.wb_data <= nxt_st.wb_data;
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  logic [DATA_W-1:0] cbits;
  // undefined control bits are masked off before use
  assign cbits = st_ff.ctl[CONTROL_BITS_OFS[3:0]] & CB_DEFINED_MASK;
  assign reg_rdata_o = st_ff.rdata;
  assign wb_valid_o = st_ff.wb_valid;
  assign wb_kind_o = st_ff.wb_kind;
  assign wb_data_o = st_ff.wb_data;
  assign poll_req_o = st_ff.poll_busy;
  assign element_word_o = st_ff.elem;
  assign screen_select_o = st_ff.ctl[SCREEN_SELECT_OFS[3:0]];
  assign copy_source_o = st_ff.ctl[COPY_SOURCE_OFS[3:0]][11:0];
  assign copy_target_o = st_ff.ctl[COPY_TARGET_OFS[3:0]][11:0];
  assign copy_type_o = st_ff.ctl[COPY_TARGET_OFS[3:0]][15:12];
  assign backlight_on_o = cbits[CB_SCREEN_ON];
  assign alarm_o = cbits[CB_ALARM];
  assign buzzer_cont_o = cbits[CB_BUZ_CONT];
  assign buzzer_inter_o = cbits[CB_BUZ_INTER];
  assign history_clear_o = cbits[CB_HIST_CLR];
  assign backlight_red_o = cbits[CB_BL_RED];
  assign backlight_steady_o = cbits[CB_BL_STEADY];
  assign gm_enabled_o = st_ff.gm_en;

  // control general memory words, zero while the switch is off
  genvar gi;
  generate
    for (gi = 0; gi < CTL_GM_WORDS; gi++) begin : g_ctl_gm
      assign ctl_gm_bits_o[gi] = (st_ff.gm_en && gi < GM_CTL_WORDS) ?
        st_ff.ctl[CTL_WORDS_NOGM + gi] : ZERO_W;
    end
  endgenerate
endmodule // terminal_status_word_exchange

/* hw/status_xchg_pkg.sv */
// package: constants and types for the terminal status word exchange
package status_xchg_pkg;
  // ******************************************************************
  // register bus
  // ******************************************************************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  // control area words, mirrored copies of host words n..n+9
  localparam logic [ADDR_W-1:0] CTL_BASE_IDX = 5'h00;
  localparam logic [ADDR_W-1:0] NTF_BASE_IDX = 5'h10;
  localparam logic [ADDR_W-1:0] CFG_IDX = 5'h1F;
  localparam logic [ADDR_W-1:0] WORD_OFS_MASK = 5'h0F;
  localparam logic [ADDR_W-1:0] SCREEN_SELECT_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] COPY_SOURCE_OFS = 5'h01;
  localparam logic [ADDR_W-1:0] COPY_TARGET_OFS = 5'h02;
  localparam logic [ADDR_W-1:0] CONTROL_BITS_OFS = 5'h03;
  localparam logic [ADDR_W-1:0] CURRENT_SCREEN_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] CHANGED_TABLE_OFS = 5'h01;
  localparam logic [ADDR_W-1:0] TERMINAL_STATE_OFS = 5'h02;
  // ******************************************************************
  // area sizes
  // ******************************************************************
  localparam int AREA_WORDS_GM = 10;
  localparam int CTL_WORDS_NOGM = 4;
  localparam int NTF_WORDS_NOGM = 3;
  localparam int CTL_GM_WORDS = 6;
  localparam int NTF_GM_WORDS = 7;
  // ******************************************************************
  // control word n+3 fields
  // ******************************************************************
  localparam int CB_SCREEN_ON = 15;
  localparam int CB_ALARM = 14;
  localparam int CB_BUZ_CONT = 13;
  localparam int CB_BUZ_INTER = 12;
  localparam int CB_HIST_CLR = 11;
  localparam int CB_BL_RED = 10;
  localparam int CB_BL_STEADY = 8;
  localparam logic [DATA_W-1:0] CB_DEFINED_MASK = 16'hFD00;
  localparam logic [DATA_W-1:0] BCD3_MASK = 16'h0FFF;
  localparam logic [DATA_W-1:0] COPY_TYPE_MASK = 16'hF000;
  // ******************************************************************
  // notify word n+2 fields
  // ******************************************************************
  localparam int NB_RUN = 15;
  localparam int NB_BATT_LOW = 13;
  localparam int NB_SCR_STB = 12;
  localparam int NB_NUM_STB = 11;
  localparam logic [DATA_W-1:0] ZERO_W = 16'h0000;
  // ******************************************************************
  // write kinds, in priority order, highest first
  // ******************************************************************
  typedef enum logic [1:0] {
    WK_NOTIFY,
    WK_TOUCH,
    WK_NUMERAL,
    WK_STRING
  } write_kind_e;
endpackage : status_xchg_pkg

/* verif/host_poll_model.sv */
// host controller model answering the element poll channel
`timescale 1ns/1ps
module host_poll_model (
  // clock, reset, pacing
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic slow_i,
  // poll channel
  input wire logic poll_req_i,
  output logic poll_ack_o,
  output logic [15:0] poll_data_o
);
  logic [3:0] wait_ff;
  logic [15:0] next_ff;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_ff <= 4'h0;
      next_ff <= 16'h1357;
      poll_ack_o <= 1'b0;
      poll_data_o <= 16'hFFFF;
    end else if (poll_ack_o) begin
      poll_ack_o <= 1'b0;
      // inverted so a stale answer never looks valid
      poll_data_o <= ~poll_data_o;
    end else if (poll_req_i && wait_ff >= (slow_i ? 4'h7 : 4'h0)) begin
      poll_ack_o <= 1'b1;
      poll_data_o <= next_ff;
      next_ff <= next_ff + 16'h2468;
      wait_ff <= 4'h0;
    end else if (poll_req_i) begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule // host_poll_model

/* verif/status_xchg_chk.sv */
// port assertions for the terminal status word exchange
`timescale 1ns/1ps
module status_xchg_chk
  import status_xchg_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  // register port and events
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic screen_change_i,
  input wire logic touch_change_i,
  input wire logic numeral_entry_i,
  input wire logic string_change_i,
  // watched outputs
  input wire logic wb_valid_o,
  input wire logic [1:0] wb_kind_o,
  input wire logic poll_req_o,
  input wire logic poll_ack_i,
  input wire logic [15:0] poll_data_i,
  input wire logic [15:0] element_word_o,
  input wire logic [15:0] screen_select_o,
  input wire logic [11:0] copy_source_o,
  input wire logic [11:0] copy_target_o,
  input wire logic [3:0] copy_type_o,
  input wire logic backlight_on_o,
  input wire logic alarm_o,
  input wire logic buzzer_cont_o,
  input wire logic buzzer_inter_o,
  input wire logic history_clear_o,
  input wire logic backlight_red_o,
  input wire logic backlight_steady_o,
  input wire logic [15:0] ctl_gm_bits_o [status_xchg_pkg::CTL_GM_WORDS],
  input wire logic gm_enabled_o
);
  // ********************
  // control word shadow
  // ********************
  logic [15:0] ctl_ff [4];
  logic [1:0] quiet_ff;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_ff <= '{default: 16'h0000};
      quiet_ff <= 2'h0;
    end else if (reg_wr_i && clk_en_i && reg_addr_i < 5'h04) begin
      ctl_ff[reg_addr_i[1:0]] <= reg_wdata_i;
      quiet_ff <= 2'h0;
    end else if (quiet_ff != 2'h3) begin
      quiet_ff <= quiet_ff + 2'h1;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // ********************
  // properties
  // ********************
  sequence settled_s;
    quiet_ff == 2'h3;
  endsequence
  sequence all_events_s;
    screen_change_i && touch_change_i && numeral_entry_i && string_change_i && clk_en_i && !wb_valid_o;
  endsequence
  sequence drain_s;
    wb_valid_o && wb_kind_o == WK_NOTIFY ##1 wb_valid_o && wb_kind_o == WK_TOUCH
      ##1 wb_valid_o && wb_kind_o == WK_NUMERAL ##1 wb_valid_o && wb_kind_o == WK_STRING;
  endsequence
  backlight_follow_a: assert property (settled_s |-> backlight_on_o == ctl_ff[3][CB_SCREEN_ON])
    else $error("backlight differs from screen display bit");
  control_bits_a: assert property (settled_s |-> {alarm_o, buzzer_cont_o, buzzer_inter_o, history_clear_o,
    backlight_red_o, backlight_steady_o} == {ctl_ff[3][14:10], ctl_ff[3][8]})
    else $error("control bit outputs differ from control word");
  copy_fields_a: assert property (settled_s |-> copy_source_o == ctl_ff[1][11:0] &&
    copy_target_o == ctl_ff[2][11:0] && copy_type_o == ctl_ff[2][15:12])
    else $error("copy fields differ from control words");
  screen_select_a: assert property (settled_s |-> screen_select_o == ctl_ff[0])
    else $error("screen select differs from control word");
  gm_off_zero_a: assert property (!gm_enabled_o [*2] |-> ctl_gm_bits_o[0] == 16'h0000 &&
    ctl_gm_bits_o[5] == 16'h0000)
    else $error("general memory words present while switched off");
  notify_first_a: assert property (screen_change_i && clk_en_i ##1 clk_en_i |=>
    wb_valid_o && wb_kind_o == WK_NOTIFY)
    else $error("screen change not written back");
  write_order_a: assert property (all_events_s |=> ##1 drain_s)
    else $error("write-back order wrong");
  poll_hold_a: assert property (poll_req_o && !poll_ack_i && clk_en_i |=> poll_req_o)
    else $error("poll request dropped before answer");
  poll_take_a: assert property (poll_ack_i && clk_en_i |=> !poll_req_o &&
    element_word_o == $past(poll_data_i))
    else $error("poll answer not taken");
endmodule // status_xchg_chk
bind terminal_status_word_exchange status_xchg_chk status_xchg_chk_i (.*);

/* verif/terminal_status_word_exchange_bench.sv */
// self-checking bench for the terminal status word exchange
`timescale 1ns/1ps
module terminal_status_word_exchange_bench;
  import status_xchg_pkg::*;
  logic sys_clk_i, nrst_i, clk_en_i, general_memory_switch_i, reg_wr_i, reg_rd_i, slow;
  logic [4:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, screen_num_i, numeral_value_i, touch_bits_i, wb_data_o;
  logic screen_change_i, numeral_entry_i, touch_change_i, string_change_i, running_i, battery_low_i;
  logic [11:0] numeral_table_i, copy_source_o, copy_target_o;
  logic [2:0] touch_word_i;
  logic [1:0] wb_kind_o;
  logic wb_valid_o, poll_req_o, poll_ack_i, gm_enabled_o;
  logic [15:0] poll_data_i, element_word_o, screen_select_o;
  logic [3:0] copy_type_o;
  logic backlight_on_o, alarm_o, buzzer_cont_o, buzzer_inter_o;
  logic history_clear_o, backlight_red_o, backlight_steady_o;
  logic [15:0] ctl_gm_bits_o [CTL_GM_WORDS];
  logic [17:0] wbq [$];
  logic [15:0] cw [3] = '{16'h8000, 16'h7D00, 16'h02FF};
  int errors = 0;
  int total_checks = 0;
  terminal_status_word_exchange terminal_status_word_exchange_i (.*);
  host_poll_model host_poll_model_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .slow_i(slow),
    .poll_req_i(poll_req_o), .poll_ack_o(poll_ack_i), .poll_data_o(poll_data_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) if (wb_valid_o === 1'b1) wbq.push_back({wb_kind_o, wb_data_o});
  // ********************
  // tasks
  // ********************
  task automatic report_and_stop;
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_word(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_word(input logic [4:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(reg_rdata_o, exp);
  endtask
  // caller raises the event at the same edge; reads run back to back
  task automatic watch_strobe(input int b);
    logic [15:0] n;
    n = 16'h0000;
    reg_addr_i <= 5'h12;
    reg_rd_i <= 1'b1;
    repeat (8) begin
      @(posedge sys_clk_i);
      screen_change_i <= 1'b0;
      numeral_entry_i <= 1'b0;
      @(negedge sys_clk_i);
      n = n + 16'(reg_rdata_o[b]);
    end
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    chk(n, 18'h1);
  endtask
  task automatic poll_check;
    logic [15:0] pd;
    int k;
    k = 0;
    while (poll_ack_i !== 1'b1) begin
      @(negedge sys_clk_i);
      k++;
      if (k > 100) begin
        errors++;
        $display("wrong value at %0t: poll never answered", $time);
        report_and_stop;
      end
    end
    pd = poll_data_i;
    @(negedge sys_clk_i);
    chk(element_word_o, pd);
  endtask
  // ********************
  // main sequence
  // ********************
  initial begin
    {nrst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, screen_change_i, screen_num_i, slow} = '0;
    {numeral_entry_i, numeral_table_i, numeral_value_i, touch_change_i, touch_bits_i} = '0;
    {touch_word_i, string_change_i, running_i, battery_low_i} = '0;
    clk_en_i = 1'b1;
    general_memory_switch_i = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    poll_check();
    @(posedge sys_clk_i) slow <= 1'b1;
    poll_check();
    rd_word(5'h1F, 16'h0001);
    wr_word(5'h00, 16'h0042);
    wr_word(5'h01, 16'h0123);
    wr_word(5'h02, 16'hA456);
    foreach (cw[i]) begin
      wr_word(5'h03, cw[i]);
      repeat (3) @(negedge sys_clk_i);
      chk({backlight_on_o, alarm_o, buzzer_cont_o, buzzer_inter_o, history_clear_o, backlight_red_o,
        backlight_steady_o}, {cw[i][15:10], cw[i][8]});
      rd_word(5'h03, cw[i]);
    end
    chk(screen_select_o, 18'h0042);
    chk(copy_source_o, 18'h0123);
    chk({copy_type_o, copy_target_o}, 18'hA456);
    wr_word(5'h09, 16'h5A5A);
    rd_word(5'h09, 16'h5A5A);
    chk(ctl_gm_bits_o[5], 18'h5A5A);
    rd_word(5'h0A, 16'h0000);
    @(posedge sys_clk_i);
    screen_num_i <= 16'h0042;
    screen_change_i <= 1'b1;
    watch_strobe(12);
    rd_word(5'h10, 16'h0042);
    wbq.delete();
    @(posedge sys_clk_i);
    numeral_table_i <= 12'h123;
    numeral_value_i <= 16'h5678;
    numeral_entry_i <= 1'b1;
    watch_strobe(11);
    rd_word(5'h11, 16'h0123);
    chk(wbq[$], {2'h2, 16'h5678});
    wbq.delete();
    @(posedge sys_clk_i);
    {touch_word_i, touch_bits_i, touch_change_i} <= {3'h6, 16'h0081, 1'b1};
    @(posedge sys_clk_i) touch_change_i <= 1'b0;
    rd_word(5'h19, 16'h0081);
    chk(18'(wbq.size() != 0), 18'h1);
    wbq.delete();
    @(posedge sys_clk_i) {screen_change_i, touch_change_i, numeral_entry_i, string_change_i} <= 4'hF;
    @(posedge sys_clk_i) {screen_change_i, touch_change_i, numeral_entry_i, string_change_i} <= 4'h0;
    repeat (8) @(posedge sys_clk_i);
    chk(18'(wbq.size()), 18'h4);
    foreach (wbq[i]) chk(wbq[i][17:16], 18'(i));
    wbq.delete();
    repeat (30) @(posedge sys_clk_i);
    chk(18'(wbq.size()), 18'h0);
    @(posedge sys_clk_i) {running_i, battery_low_i} <= 2'h3;
    repeat (10) @(posedge sys_clk_i);
    rd_word(5'h12, 16'hA000);
    chk(wbq[0][17:16], 18'h0);
    wr_word(5'h10, 16'hFFFF);
    rd_word(5'h10, 16'h0042);
    @(posedge sys_clk_i) clk_en_i <= 1'b0;
    wr_word(5'h00, 16'h0099);
    @(posedge sys_clk_i) clk_en_i <= 1'b1;
    rd_word(5'h00, 16'h0042);
    @(posedge sys_clk_i) general_memory_switch_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    wr_word(5'h04, 16'h1111);
    rd_word(5'h04, 16'h0000);
    rd_word(5'h19, 16'h0000);
    rd_word(5'h1F, 16'h0000);
    rd_word(5'h03, 16'h02FF);
    chk(ctl_gm_bits_o[5], 18'h0);
    report_and_stop;
  end
endmodule // terminal_status_word_exchange_bench
